//--- design/mos_alarm_hold.sv
// mos_alarm_hold: one alarm output, latching or momentary
`timescale 1ns/100ps
module mos_alarm_hold
  import mos_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_latch_en,
  input wire logic i_trip,
  input wire logic i_clear,
  output logic o_alarm
);

  logic next_alarm;

  // ----------------------------------------------------------------
  // hold logic
  // ----------------------------------------------------------------
  // a trip in the clear cycle wins, so no event is lost
  always_comb begin
    if (i_latch_en) begin
      next_alarm = i_trip | (o_alarm & ~i_clear);
    end else begin
      next_alarm = i_trip;
    end
  end

  // state register
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_alarm <= 1'b0;
    end else begin
      o_alarm <= next_alarm;
    end
  end

endmodule : mos_alarm_hold

//--- design/mos_pkg.sv
// mos_pkg: shared constants and types for the module option setup bytes
package mos_pkg;

  // ----------------------------------------------------------------
  // link options byte field positions
  // ----------------------------------------------------------------
  localparam int MOS_LNK_LF_BIT = 7;
  localparam int MOS_LNK_PAR_ODD_BIT = 6;
  localparam int MOS_LNK_PAR_EN_BIT = 5;
  localparam int MOS_LNK_EXT_ADDR_BIT = 4;
  localparam int MOS_LNK_BAUD_LSB = 0;
  localparam int MOS_BAUD_W = 4;

  // ----------------------------------------------------------------
  // module options byte field positions
  // ----------------------------------------------------------------
  localparam int MOS_OPT_ALM_EN_BIT = 7;
  localparam int MOS_OPT_LO_LATCH_BIT = 6;
  localparam int MOS_OPT_HI_LATCH_BIT = 5;
  localparam int MOS_OPT_VARIANT_BIT = 4;
  localparam int MOS_OPT_FAHR_BIT = 3;
  localparam int MOS_OPT_ECHO_BIT = 2;

  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0] MOS_OPT_RESET = 8'h01;
  localparam logic [7:0] MOS_LNK_RESET = 8'h07;
  localparam int MOS_DEFAULT_BAUD_RATE = 300;
  localparam logic [MOS_BAUD_W-1:0] MOS_BAUD_CODE_300 = 4'h7;
  localparam int MOS_CJC_FIXED_REF_DEGC = 0;

  // ----------------------------------------------------------------
  // alarm channels
  // ----------------------------------------------------------------
  localparam int MOS_NUM_ALARMS = 2;
  localparam int MOS_ALM_LO = 0;
  localparam int MOS_ALM_HI = 1;
  localparam int MOS_CMD_LATCH_BIT = 0;

  // decoded host commands that touch the setup bytes
  typedef enum logic [2:0] {
    MOS_OP_NONE = 3'h0,
    MOS_OP_SETUP_WRITE = 3'h1,
    MOS_OP_ALARMS_ON = 3'h2,
    MOS_OP_ALARMS_OFF = 3'h3,
    MOS_OP_LOW_ALARM = 3'h4,
    MOS_OP_HIGH_ALARM = 3'h5,
    MOS_OP_MODULE_RESET = 3'h6,
    MOS_OP_ALARM_CLEAR = 3'h7
  } mos_op_t;

  // one command: data[15:8] link byte, data[7:0] options byte
  typedef struct packed {
    logic valid;
    mos_op_t op;
    logic [15:0] data;
  } mos_cmd_t;

  // received character with its parity bit
  typedef struct packed {
    logic valid;
    logic parity;
    logic [7:0] char;
  } mos_char_t;

endpackage : mos_pkg

//--- design/mos_setup_bytes.sv
// mos_setup_bytes: link and module option setup bytes with their effects
`timescale 1ns/100ps
module mos_setup_bytes
  import mos_pkg::*;
#(
  parameter logic [7:0] LINK_RESET = MOS_LNK_RESET
) (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire mos_cmd_t i_cmd,
  input wire logic i_default_mode_pin,
  input wire logic i_variant_rtd_pin,
  input wire mos_char_t i_rx,
  input wire logic [7:0] i_tx_char,
  input wire logic i_low_trip,
  input wire logic i_high_trip,
  input wire logic [MOS_NUM_ALARMS-1:0] i_dout,
  output logic [7:0] o_link_options,
  output logic [7:0] o_module_options,
  output logic [MOS_BAUD_W-1:0] o_baud_code,
  output logic o_linefeed_en,
  output logic o_ext_addr_en,
  output logic o_parity_en,
  output logic o_parity_odd,
  output logic o_tx_parity,
  output logic o_rx_parity_err,
  output logic o_cjc_fixed_ref,
  output logic o_four_wire,
  output logic o_fahrenheit,
  output logic o_echo_valid,
  output logic [7:0] o_echo_char,
  output logic [MOS_NUM_ALARMS-1:0] o_alarm_state,
  output logic [MOS_NUM_ALARMS-1:0] o_terminal
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // both pins come from outside the clock domain; stage one is
  // read only by stage two
  logic default_meta;
  logic default_sync;
  logic variant_meta;
  logic variant_sync;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      default_meta <= 1'b0;
      default_sync <= 1'b0;
      variant_meta <= 1'b0;
      variant_sync <= 1'b0;
    end else begin
      default_meta <= i_default_mode_pin;
      default_sync <= default_meta;
      variant_meta <= i_variant_rtd_pin;
      variant_sync <= variant_meta;
    end
  end

  // ----------------------------------------------------------------
  // setup byte storage
  // ----------------------------------------------------------------
  logic [7:0] link_options_setup;
  logic [7:0] module_options_setup;
  logic [MOS_BAUD_W-1:0] baud_active;
  logic [7:0] next_link_options_setup;
  logic [7:0] next_module_options_setup;
  logic [MOS_BAUD_W-1:0] next_baud_active;
  logic cmd_hit;

  assign cmd_hit = i_cmd.valid;

  // command decode; each command touches only its own bits
  always_comb begin
    next_link_options_setup = link_options_setup;
    next_module_options_setup = module_options_setup;
    next_baud_active = baud_active;
    if (cmd_hit) begin
      unique case (i_cmd.op)
        MOS_OP_SETUP_WRITE: begin
          // baud field is stored here but not put to use
          next_link_options_setup = i_cmd.data[15:8];
          next_module_options_setup = i_cmd.data[7:0];
        end
        MOS_OP_ALARMS_ON: begin
          next_module_options_setup[MOS_OPT_ALM_EN_BIT] = 1'b1;
        end
        MOS_OP_ALARMS_OFF: begin
          next_module_options_setup[MOS_OPT_ALM_EN_BIT] = 1'b0;
        end
        MOS_OP_LOW_ALARM: begin
          next_module_options_setup[MOS_OPT_LO_LATCH_BIT] =
            i_cmd.data[MOS_CMD_LATCH_BIT];
        end
        MOS_OP_HIGH_ALARM: begin
          next_module_options_setup[MOS_OPT_HI_LATCH_BIT] =
            i_cmd.data[MOS_CMD_LATCH_BIT];
        end
        MOS_OP_MODULE_RESET: begin
          // only a module reset moves the stored baud code into use
          next_baud_active =
            link_options_setup[MOS_LNK_BAUD_LSB +: MOS_BAUD_W];
        end
        MOS_OP_ALARM_CLEAR: begin
          next_baud_active = baud_active;
        end
        MOS_OP_NONE: begin
          next_baud_active = baud_active;
        end
      endcase
    end
  end

  // storage registers; reset also loads the active baud code
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      link_options_setup <= LINK_RESET;
      module_options_setup <= MOS_OPT_RESET;
      baud_active <= LINK_RESET[MOS_LNK_BAUD_LSB +: MOS_BAUD_W];
    end else begin
      link_options_setup <= next_link_options_setup;
      module_options_setup <= next_module_options_setup;
      baud_active <= next_baud_active;
    end
  end

  // ----------------------------------------------------------------
  // alarm hold channels
  // ----------------------------------------------------------------
  logic [MOS_NUM_ALARMS-1:0] alarm_trip;
  logic [MOS_NUM_ALARMS-1:0] alarm_latch_en;
  logic [MOS_NUM_ALARMS-1:0] alarm_held;
  logic alarm_clear;

  assign alarm_trip[MOS_ALM_LO] = i_low_trip;
  assign alarm_trip[MOS_ALM_HI] = i_high_trip;
  // latch choice per channel comes straight from the options byte
  assign alarm_latch_en[MOS_ALM_LO] = module_options_setup[MOS_OPT_LO_LATCH_BIT];
  assign alarm_latch_en[MOS_ALM_HI] = module_options_setup[MOS_OPT_HI_LATCH_BIT];
  assign alarm_clear = cmd_hit & (i_cmd.op == MOS_OP_ALARM_CLEAR);

  generate
    for (genvar g = 0; g < MOS_NUM_ALARMS; g++) begin : g_alarm
      mos_alarm_hold u_hold (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_latch_en(alarm_latch_en[g]),
        .i_trip(alarm_trip[g]),
        .i_clear(alarm_clear),
        .o_alarm(alarm_held[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // character path: parity and echo
  // ----------------------------------------------------------------
  logic par_en;
  logic par_odd;
  logic tx_calc;
  logic rx_calc;

  assign par_en = link_options_setup[MOS_LNK_PAR_EN_BIT];
  assign par_odd = link_options_setup[MOS_LNK_PAR_ODD_BIT];

  // parity bit for a character: even makes the count even
  always_comb begin
    tx_calc = (^i_tx_char) ^ par_odd;
    rx_calc = (^i_rx.char) ^ par_odd;
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  // every output is registered so the far side sees clean levels
  logic [MOS_BAUD_W-1:0] next_baud_code;
  logic next_linefeed_en;
  logic next_ext_addr_en;
  logic next_tx_parity;
  logic next_rx_parity_err;
  logic next_cjc_fixed_ref;
  logic next_four_wire;
  logic next_fahrenheit;
  logic next_echo_valid;
  logic [7:0] next_echo_char;
  logic [MOS_NUM_ALARMS-1:0] next_terminal;
  logic opt_variant;

  assign opt_variant = module_options_setup[MOS_OPT_VARIANT_BIT];

  always_comb begin
    // default mode overrides whatever baud code is in use
    if (default_sync) begin
      next_baud_code = MOS_BAUD_CODE_300;
    end else begin
      next_baud_code = baud_active;
    end
    next_linefeed_en = link_options_setup[MOS_LNK_LF_BIT];
    next_ext_addr_en = link_options_setup[MOS_LNK_EXT_ADDR_BIT];
    // disabled parity sends a one in the parity slot
    next_tx_parity = par_en ? tx_calc : 1'b1;
    // received parity is ignored while checking is off
    next_rx_parity_err = i_rx.valid & par_en & (rx_calc != i_rx.parity);
    // bit 4 means fixed cjc reference on one variant and four-wire on the other
    next_cjc_fixed_ref = ~variant_sync & opt_variant;
    next_four_wire = variant_sync & opt_variant;
    // scale flag goes to the reading path only; limits stay raw
    next_fahrenheit = module_options_setup[MOS_OPT_FAHR_BIT];
    next_echo_valid = i_rx.valid & module_options_setup[MOS_OPT_ECHO_BIT];
    next_echo_char = i_rx.valid ? i_rx.char : o_echo_char;
    // terminals carry alarms only while routed, else the output command
    if (module_options_setup[MOS_OPT_ALM_EN_BIT]) begin
      next_terminal = alarm_held;
    end else begin
      next_terminal = i_dout;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_link_options <= LINK_RESET;
      o_module_options <= MOS_OPT_RESET;
      o_baud_code <= MOS_BAUD_CODE_300;
      o_linefeed_en <= 1'b0;
      o_ext_addr_en <= 1'b0;
      o_parity_en <= 1'b0;
      o_parity_odd <= 1'b0;
      o_tx_parity <= 1'b1;
      o_rx_parity_err <= 1'b0;
      o_cjc_fixed_ref <= 1'b0;
      o_four_wire <= 1'b0;
      o_fahrenheit <= 1'b0;
      o_echo_valid <= 1'b0;
      o_echo_char <= 8'h00;
      o_alarm_state <= '0;
      o_terminal <= '0;
    end else begin
      o_link_options <= link_options_setup;
      o_module_options <= module_options_setup;
      o_baud_code <= next_baud_code;
      o_linefeed_en <= next_linefeed_en;
      o_ext_addr_en <= next_ext_addr_en;
      o_parity_en <= par_en;
      o_parity_odd <= par_odd;
      o_tx_parity <= next_tx_parity;
      o_rx_parity_err <= next_rx_parity_err;
      o_cjc_fixed_ref <= next_cjc_fixed_ref;
      o_four_wire <= next_four_wire;
      o_fahrenheit <= next_fahrenheit;
      o_echo_valid <= next_echo_valid;
      o_echo_char <= next_echo_char;
      o_alarm_state <= alarm_held;
      o_terminal <= next_terminal;
    end
  end

endmodule : mos_setup_bytes

//--- test/mos_host_model.sv
// mos_host_model: host side that sends setup commands and characters
`timescale 1ns/100ps
module mos_host_model
  import mos_pkg::*;
#(
  parameter bit CHAIN = 1'b0,
  parameter bit MULTIDROP = 1'b0,
  parameter bit TEMP_OUT = 1'b1
) (
  input wire logic i_sys_clk,
  output mos_cmd_t o_cmd = '0,
  output mos_char_t o_rx = '0
);
  // hold lets back-to-back commands go out with no idle cycle between them
  task automatic send_cmd(input mos_op_t op, input logic [15:0] d, input bit hold);
    d[MOS_OPT_ECHO_BIT] = (d[MOS_OPT_ECHO_BIT] || CHAIN) && !MULTIDROP;
    // a variant with no temperature reading must never be asked for the other scale
    d[MOS_OPT_FAHR_BIT] = d[MOS_OPT_FAHR_BIT] && TEMP_OUT;
    o_cmd <= '{1'b1, op, d};
    @(posedge i_sys_clk);
    if (!hold)
      o_cmd <= '{1'b0, MOS_OP_NONE, ~d};
  endtask : send_cmd
  // idle data lines show the inverse of the last character, never a stale copy
  task automatic send_char(input logic [7:0] c, input logic p);
    o_rx <= '{1'b1, p, c};
    @(posedge i_sys_clk);
    o_rx <= '{1'b0, ~p, ~c};
  endtask : send_char
endmodule : mos_host_model

//--- test/mos_setup_bytes_bench.sv
// mos_setup_bytes_bench: self-checking bench for the setup bytes block
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module mos_setup_bytes_bench
  import mos_pkg::*;
;
  logic i_sys_clk = 1'b0, i_sys_rst = 1'b1, i_default_mode_pin = 1'b0, i_variant_rtd_pin = 1'b0;
  logic i_low_trip = 1'b0, i_high_trip = 1'b0;
  logic [7:0] i_tx_char = 8'h00;
  logic [MOS_NUM_ALARMS-1:0] i_dout = 2'h0;
  mos_cmd_t i_cmd;
  mos_char_t i_rx;
  logic [7:0] o_link_options, o_module_options, o_echo_char;
  logic [MOS_BAUD_W-1:0] o_baud_code;
  logic o_linefeed_en, o_ext_addr_en, o_parity_en, o_parity_odd, o_tx_parity, o_rx_parity_err;
  logic o_cjc_fixed_ref, o_four_wire, o_fahrenheit, o_echo_valid;
  logic [MOS_NUM_ALARMS-1:0] o_alarm_state, o_terminal;
  // reference copy of the stored bytes and of the baud code in use
  logic [7:0] m_opt = 8'h01, m_link = MOS_LNK_RESET;
  logic [3:0] m_baud = 4'h7;
  logic [31:0] seed = 32'h18873309;
  int fail_count = 0, tests_run = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  mos_setup_bytes i_dut (.*);
  mos_host_model u_host (
    .i_sys_clk(i_sys_clk),
    .o_cmd(i_cmd),
    .o_rx(i_rx)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // wait whole cycles, then step past the edge so outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : settle
  // update the reference first, then let the host send the command
  task automatic cmd(input mos_op_t op, input logic [15:0] d, input bit hold);
    case (op)
      MOS_OP_SETUP_WRITE: {m_link, m_opt} = d;
      MOS_OP_ALARMS_ON: m_opt[7] = 1'b1;
      MOS_OP_ALARMS_OFF: m_opt[7] = 1'b0;
      MOS_OP_LOW_ALARM: m_opt[6] = d[0];
      MOS_OP_HIGH_ALARM: m_opt[5] = d[0];
      MOS_OP_MODULE_RESET: m_baud = m_link[3:0];
      default: ;
    endcase
    u_host.send_cmd(op, d, hold);
  endtask : cmd
  task automatic chk_cfg;
    `CHK(o_module_options, m_opt);
    `CHK(o_link_options, m_link);
    `CHK(o_baud_code, m_baud);
    `CHK(o_ext_addr_en, m_link[4]);
    `CHK({o_linefeed_en, o_parity_odd, o_parity_en}, m_link[7:5]);
    `CHK(o_fahrenheit, m_opt[3]);
    `CHK({o_four_wire, o_cjc_fixed_ref}, {2{m_opt[4]}} & {i_variant_rtd_pin, !i_variant_rtd_pin});
  endtask : chk_cfg
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    settle(3);
    chk_cfg;
    // random setup bytes, variant pin random; baud must wait for module reset
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      i_variant_rtd_pin <= seed[20];
      cmd(MOS_OP_SETUP_WRITE, {seed[15:12], 4'(seed[11:8] % 10), seed[7:0]}, 1'b0);
      settle(4);
      chk_cfg;
    end
    cmd(MOS_OP_MODULE_RESET, 16'h0000, 1'b0);
    settle(2);
    chk_cfg;
    // held so the next command takes over the strobe without a second release in this step
    cmd(MOS_OP_ALARMS_ON, 16'h0000, 1'b1);
    // every latch pairing, both commands back to back
    for (int k = 0; k < 4; k++) begin
      cmd(MOS_OP_LOW_ALARM, {15'h0000, k[0]}, 1'b1);
      cmd(MOS_OP_HIGH_ALARM, {15'h0000, k[1]}, 1'b0);
      {i_high_trip, i_low_trip} <= 2'b11;
      settle(3);
      `CHK(o_terminal, 2'b11);
      {i_high_trip, i_low_trip} <= 2'b00;
      settle(3);
      `CHK(o_alarm_state, {m_opt[5], m_opt[6]});
      chk_cfg;
      cmd(MOS_OP_ALARM_CLEAR, 16'h0000, 1'b0);
      settle(2);
      `CHK(o_alarm_state, 2'b00);
    end
    cmd(MOS_OP_ALARMS_OFF, 16'h0000, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i_dout <= k[1:0];
      i_high_trip <= k[0];
      settle(3);
      `CHK(o_terminal, k[1:0]);
    end
    i_high_trip <= 1'b0;
    // each parity mode with a random character and parity bit
    for (int p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      cmd(MOS_OP_SETUP_WRITE, {1'b0, p[1:0], 1'b1, m_link[3:0], m_opt[7:3], seed[9], 2'b01}, 1'b0);
      settle(2);
      chk_cfg;
      i_tx_char <= seed[7:0];
      u_host.send_char(seed[15:8], seed[16]);
      #1;
      `CHK(o_echo_valid, m_opt[2]);
      `CHK(o_echo_char, seed[15:8]);
      `CHK(o_rx_parity_err, m_link[5] && ((^seed[16:8]) != m_link[6]));
      `CHK(o_tx_parity, m_link[5] ? (^seed[7:0]) ^ m_link[6] : 1'b1);
    end
    i_default_mode_pin <= 1'b1;
    settle(5);
    `CHK(o_baud_code, MOS_BAUD_CODE_300);
    `CHK(o_link_options, m_link);
    i_default_mode_pin <= 1'b0;
    settle(5);
    chk_cfg;
    conclude;
  end
  // the sequence needs well under 400 cycles, so this only cuts a hang
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    fail_count++;
    conclude;
  end
endmodule : mos_setup_bytes_bench

//--- test/mos_setup_bytes_checker.sv
// mos_setup_bytes_checker: concurrent checks on the setup bytes ports
`timescale 1ns/100ps
module mos_setup_bytes_checker
  import mos_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire mos_cmd_t i_cmd,
  input wire logic i_default_mode_pin,
  input wire mos_char_t i_rx,
  input wire logic [7:0] i_tx_char,
  input wire logic [7:0] o_module_options,
  input wire logic [MOS_BAUD_W-1:0] o_baud_code,
  input wire logic o_parity_en,
  input wire logic o_parity_odd,
  input wire logic o_tx_parity,
  input wire logic o_echo_valid,
  input wire logic [MOS_NUM_ALARMS-1:0] o_alarm_state,
  input wire logic [MOS_NUM_ALARMS-1:0] o_terminal
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // one host command of the given kind taken on this edge
  sequence cmd_s(mos_op_t op);
    i_cmd.valid && i_cmd.op == op;
  endsequence
  // strap low long enough to have left the synchroniser
  sequence strap_low_s;
    !i_default_mode_pin [*5];
  endsequence
  opt_reset_a: assert property ($fell(i_sys_rst) |-> o_module_options == MOS_OPT_RESET)
    else $error("options byte not at reset value");
  alarm_enable_a: assert property ((cmd_s(MOS_OP_ALARMS_ON) or cmd_s(MOS_OP_ALARMS_OFF)) |->
    ##2 o_module_options[7] == ($past(i_cmd.op, 2) == MOS_OP_ALARMS_ON)) else $error("alarm enable bit wrong");
  high_cmd_a: assert property (cmd_s(MOS_OP_HIGH_ALARM) |-> ##2 o_module_options[5] == $past(i_cmd.data[0], 2)
    && $stable(o_module_options[7:6]) && $stable(o_module_options[4:0])) else $error("high latch update wrong");
  alarm_route_a: assert property (o_module_options[7] |-> o_terminal == o_alarm_state)
    else $error("terminals not following alarms");
  echo_pulse_a: assert property (!$past(i_sys_rst) |-> o_echo_valid == ($past(i_rx.valid) && o_module_options[2]))
    else $error("echo pulse wrong");
  tx_parity_a: assert property (!$past(i_sys_rst) |->
    o_tx_parity == (o_parity_en ? (^$past(i_tx_char)) ^ o_parity_odd : 1'b1)) else $error("tx parity wrong");
  default_baud_a: assert property (i_default_mode_pin [*5] |-> o_baud_code == MOS_BAUD_CODE_300)
    else $error("default mode baud not forced");
  baud_defer_a: assert property (strap_low_s ##0 cmd_s(MOS_OP_SETUP_WRITE) |-> ##2 $stable(o_baud_code))
    else $error("baud changed without module reset");
endmodule : mos_setup_bytes_checker
bind mos_setup_bytes mos_setup_bytes_checker i_chk (.*);
